// >>> rtl/dmt_pkg.sv
// Package for the downconverter mode and test control block.
// Assumes a single 200 MHz core clock and byte-wide register access.
package dmt_pkg;

    // Register offsets
    localparam logic [15:0] ADDR_ONE_TEST   = 16'h0347;
    localparam logic [15:0] ADDR_TWO_CTRL   = 16'h0350;
    localparam logic [15:0] ADDR_PAT_SELECT = 16'h0550;

    // Reset values
    localparam logic [7:0] RST_ONE_TEST   = 8'h00;
    localparam logic [7:0] RST_TWO_CTRL   = 8'h00;
    localparam logic [3:0] RST_PAT_SELECT = 4'h0;

    // Field positions of the first downconverter test register
    localparam int BIT_TEST_I = 0;
    localparam int BIT_TEST_Q = 2;
    localparam logic [7:0] MASK_ONE_TEST = 8'h05;

    // Field positions of the second downconverter control register
    localparam int BIT_MIXER    = 7;
    localparam int BIT_GAIN     = 6;
    localparam int POS_IF_HI    = 5;
    localparam int POS_IF_LO    = 4;
    localparam int BIT_C2R      = 3;
    localparam int POS_DEC_HI   = 2;
    localparam int POS_DEC_LO   = 0;
    localparam int PAT_SEL_BITS = 4;

    // IF mode codes
    localparam logic [1:0] IF_VARIABLE = 2'h0;
    localparam logic [1:0] IF_ZERO     = 2'h1;
    localparam logic [1:0] IF_QUARTER  = 2'h2;
    localparam logic [1:0] IF_TEST     = 2'h3;

    // Decimation codes
    localparam logic [2:0] DEC_HB12     = 3'h0;
    localparam logic [2:0] DEC_HB123    = 3'h1;
    localparam logic [2:0] DEC_HB1234   = 3'h2;
    localparam logic [2:0] DEC_HB1      = 3'h3;
    localparam logic [2:0] DEC_HB1_TB   = 3'h4;
    localparam logic [2:0] DEC_HB12_TB  = 3'h5;
    localparam logic [2:0] DEC_HB123_TB = 3'h6;

    // Stage factors and output scaling (sum * mul >>> shift)
    localparam int HALF_FACTOR  = 2;
    localparam int HALF_MUL     = 1;
    localparam int HALF_SHIFT   = 1;
    localparam int THIRD_FACTOR = 3;
    localparam int THIRD_MUL    = 11;
    localparam int THIRD_SHIFT  = 5;

endpackage

// >>> rtl/dmt_dec_stage.sv
// One decimation stage: boxcar average over FACTOR samples, or bypass.
// Assumes in_valid from logic on the same clock; ce freezes all state.
`timescale 1ns/1ps
module dmt_dec_stage
    import dmt_pkg::*;
#(
    parameter int DW     = 16,
    parameter int FACTOR = 2,
    parameter int MUL    = 1,
    parameter int SHIFT  = 1
) (
    input  wire logic                 core_clk,
    input  wire logic                 arst_n,
    input  wire logic                 ce,
    input  wire logic                 bypass,
    input  wire logic                 clear,
    input  wire logic                 in_valid,
    input  wire logic signed [DW-1:0] in_i,
    input  wire logic signed [DW-1:0] in_q,
    output logic                      out_valid,
    output logic signed [DW-1:0]      out_i,
    output logic signed [DW-1:0]      out_q
);
    localparam int AW = DW + 2;
    localparam int PW = AW + 5;

    // Refuse factors other than two and three, and widths under four bits
    if (FACTOR < 2 || FACTOR > 3 || DW < 4) begin : g_bad_param
        $error("dmt_dec_stage: unsupported FACTOR or DW");
    end

    logic        [1:0]    phase;
    logic signed [AW-1:0] acc_i;
    logic signed [AW-1:0] acc_q;
    logic signed [AW-1:0] sum_i;
    logic signed [AW-1:0] sum_q;
    logic signed [PW-1:0] prod_i;
    logic signed [PW-1:0] prod_q;

    // Running sums and scaled averages
    always_comb begin
        sum_i  = acc_i + AW'(in_i);
        sum_q  = acc_q + AW'(in_q);
        prod_i = (PW'(sum_i) * PW'(MUL)) >>> SHIFT;
        prod_q = (PW'(sum_q) * PW'(MUL)) >>> SHIFT;
    end

    // Accumulate FACTOR samples, then emit one
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            phase     <= 2'h0;
            acc_i     <= '0;
            acc_q     <= '0;
            out_valid <= 1'b0;
            out_i     <= '0;
            out_q     <= '0;
        end else if (ce) begin
            out_valid <= 1'b0;
            if (clear) begin
                phase <= 2'h0;
                acc_i <= '0;
                acc_q <= '0;
            end else if (in_valid) begin
                if (bypass) begin
                    out_valid <= 1'b1;
                    out_i     <= in_i;
                    out_q     <= in_q;
                end else if (phase == 2'(FACTOR - 1)) begin
                    out_valid <= 1'b1;
                    out_i     <= DW'(prod_i);
                    out_q     <= DW'(prod_q);
                    phase     <= 2'h0;
                    acc_i     <= '0;
                    acc_q     <= '0;
                end else begin
                    acc_i <= sum_i;
                    acc_q <= sum_q;
                    phase <= phase + 2'h1;
                end
            end
        end
    end
endmodule

// >>> rtl/dmt_ctrl.sv
// Downconverter mode and test control: registers, test substitution on
// the first downconverter, mixer and decimation chain of the second.
// Assumes register strobes and samples come from logic on core_clk.
//
// Notes on behaviour
// - Test bit 2 set replaces first downconverter Q samples with source B.
// - Test bit 0 set replaces first downconverter I samples with source A.
// - Pattern of sources A and B chosen by separate four-bit select field.
// - Control bit 7: 0 real mixer, one channel; 1 complex, two channels.
// - Control bit 6: 0 unity gain, 1 doubles samples (6 dB).
// - Control bit 3 clear: I and Q valid; set: real I via fs/4 mix.
// - Code 000 uses half-band one and two; decimate 2 or 4.
// - Code 001 uses half-band one to three; decimate 4 or 8.
// - Code 010 uses half-band one to four; decimate 8 or 16.
// - Code 011 uses half-band one only; decimate 1 or 2.
// - Code 100 uses half-band one plus third-band; decimate 3 or 6.
// - Code 101 uses half-band one, two, third-band; decimate 6 or 12.
// - Code 110 uses half-band one to three, third-band; decimate 12 or 24.
`timescale 1ns/1ps
module dmt_ctrl
    import dmt_pkg::*;
#(
    parameter int DW = 16
) (
    input  wire logic                   core_clk,
    input  wire logic                   arst_n,
    input  wire logic                   ce,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    input  wire logic [15:0]            reg_addr,
    input  wire logic [7:0]             reg_wdata,
    output logic      [7:0]             reg_rdata,
    input  wire logic                   one_valid_in,
    input  wire logic signed [DW-1:0]   one_i_in,
    input  wire logic signed [DW-1:0]   one_q_in,
    input  wire logic signed [DW-1:0]   pattern_a,
    input  wire logic signed [DW-1:0]   pattern_b,
    output logic                        one_valid_out,
    output logic signed [DW-1:0]        one_i_out,
    output logic signed [DW-1:0]        one_q_out,
    output logic      [PAT_SEL_BITS-1:0] pattern_select,
    input  wire logic                   two_valid_in,
    input  wire logic signed [DW-1:0]   two_a_in,
    input  wire logic signed [DW-1:0]   two_b_in,
    output logic                        two_valid_out,
    output logic signed [DW-1:0]        two_i_out,
    output logic signed [DW-1:0]        two_q_out
);
    if (DW < 4) begin : g_bad_width
        $error("dmt_ctrl: DW too small");
    end

    logic [7:0] one_test;
    logic [7:0] two_ctrl;
    logic       cfg_clear;

    // Register writes; a control write resynchronises the decimators
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            one_test       <= RST_ONE_TEST;
            two_ctrl       <= RST_TWO_CTRL;
            pattern_select <= RST_PAT_SELECT;
            cfg_clear      <= 1'b0;
        end else if (ce) begin
            cfg_clear <= reg_wr && (reg_addr == ADDR_TWO_CTRL);
            if (reg_wr) begin
                unique case (reg_addr)
                    ADDR_ONE_TEST:   one_test <= reg_wdata & MASK_ONE_TEST;
                    ADDR_TWO_CTRL:   two_ctrl <= reg_wdata;
                    ADDR_PAT_SELECT: pattern_select <= reg_wdata[3:0];
                    default: ;
                endcase
            end
        end
    end

    // Register reads, one cycle later; unmapped reads give zero
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 8'h00;
        end else if (ce && reg_rd) begin
            unique case (reg_addr)
                ADDR_ONE_TEST:   reg_rdata <= one_test;
                ADDR_TWO_CTRL:   reg_rdata <= two_ctrl;
                ADDR_PAT_SELECT: reg_rdata <= {4'h0, pattern_select};
                default:         reg_rdata <= 8'h00;
            endcase
        end
    end

    // First downconverter: optional test substitution per lane
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            one_valid_out <= 1'b0;
            one_i_out     <= '0;
            one_q_out     <= '0;
        end else if (ce) begin
            one_valid_out <= one_valid_in;
            if (one_valid_in) begin
                one_i_out <= one_test[BIT_TEST_I] ? pattern_a : one_i_in;
                one_q_out <= one_test[BIT_TEST_Q] ? pattern_b : one_q_in;
            end
        end
    end

    // Control field decode
    logic       mix_complex;
    logic       gain_double;
    logic [1:0] if_mode;
    logic       c2r;
    logic [2:0] dec_code;
    logic [3:0] stage_on;  // half-band two, three, four, third-band

    assign mix_complex = two_ctrl[BIT_MIXER];
    assign gain_double = two_ctrl[BIT_GAIN];
    assign if_mode     = two_ctrl[POS_IF_HI:POS_IF_LO];
    assign c2r         = two_ctrl[BIT_C2R];
    assign dec_code    = two_ctrl[POS_DEC_HI:POS_DEC_LO];

    // Stage selection per decimation code; half-band one runs unless c2r is set
    always_comb begin
        unique case (dec_code)
            DEC_HB12:     stage_on = 4'b0001;
            DEC_HB123:    stage_on = 4'b0011;
            DEC_HB1234:   stage_on = 4'b0111;
            DEC_HB1:      stage_on = 4'b0000;
            DEC_HB1_TB:   stage_on = 4'b1000;
            DEC_HB12_TB:  stage_on = 4'b1001;
            DEC_HB123_TB: stage_on = 4'b1011;
            default:      stage_on = 4'b0001;
        endcase
    end

    // Input mixer: channel choice and IF mode rotation
    logic                 mix_valid;
    logic signed [DW-1:0] mix_i;
    logic signed [DW-1:0] mix_q;
    logic        [1:0]    rot_phase;
    logic signed [DW-1:0] src_i;
    logic signed [DW-1:0] src_q;
    logic signed [DW-1:0] ramp;

    always_comb begin
        src_i = two_a_in;
        src_q = mix_complex ? two_b_in : '0;
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            mix_valid <= 1'b0;
            mix_i     <= '0;
            mix_q     <= '0;
            rot_phase <= 2'h0;
            ramp      <= '0;
        end else if (ce) begin
            // A sample arriving with the clear pulse is dropped, not resent
            mix_valid <= two_valid_in && !cfg_clear;
            if (cfg_clear) begin
                rot_phase <= 2'h0;
            end else if (two_valid_in) begin
                rot_phase <= rot_phase + 2'h1;
                ramp      <= ramp + DW'(1);
                unique case (if_mode)
                    IF_QUARTER: begin
                        unique case (rot_phase)
                            2'h0: begin mix_i <= src_i;  mix_q <= src_q;  end
                            2'h1: begin mix_i <= src_q;  mix_q <= -src_i; end
                            2'h2: begin mix_i <= -src_i; mix_q <= -src_q; end
                            default: begin mix_i <= -src_q; mix_q <= src_i; end
                        endcase
                    end
                    IF_TEST: begin
                        mix_i <= ramp;
                        mix_q <= ~ramp;
                    end
                    default: begin
                        mix_i <= src_i;
                        mix_q <= src_q;
                    end
                endcase
            end
        end
    end

    // Decimation chain: half-band one to four, then third-band
    logic                 st_valid [0:5];
    logic signed [DW-1:0] st_i     [0:5];
    logic signed [DW-1:0] st_q     [0:5];
    logic         [4:0]   st_bypass;

    assign st_valid[0] = mix_valid;
    assign st_i[0]     = mix_i;
    assign st_q[0]     = mix_q;
    // Half-band one keeps the full rate when real output is built
    assign st_bypass   = {~stage_on, c2r};

    for (genvar s = 0; s < 5; s++) begin : g_stage
        localparam int F = (s == 4) ? THIRD_FACTOR : HALF_FACTOR;
        localparam int M = (s == 4) ? THIRD_MUL : HALF_MUL;
        localparam int S = (s == 4) ? THIRD_SHIFT : HALF_SHIFT;
        dmt_dec_stage #(
            .DW     (DW),
            .FACTOR (F),
            .MUL    (M),
            .SHIFT  (S)
        ) u_stage (
            .core_clk  (core_clk),
            .arst_n    (arst_n),
            .ce        (ce),
            .bypass    (st_bypass[s]),
            .clear     (cfg_clear),
            .in_valid  (st_valid[s]),
            .in_i      (st_i[s]),
            .in_q      (st_q[s]),
            .out_valid (st_valid[s+1]),
            .out_i     (st_i[s+1]),
            .out_q     (st_q[s+1])
        );
    end

    // Saturating doubling
    function automatic logic signed [DW-1:0] dbl(
        input logic signed [DW-1:0] x
    );
        logic signed [DW-1:0] r;
        r = {x[DW-2:0], 1'b0};
        if (x[DW-1] != x[DW-2]) begin
            r = x[DW-1] ? {1'b1, {(DW-1){1'b0}}} : {1'b0, {(DW-1){1'b1}}};
        end
        return r;
    endfunction

    logic        [1:0]    c2r_phase;
    logic signed [DW-1:0] real_i;

    // Complex to real: real part after a further fs/4 rotation
    always_comb begin
        unique case (c2r_phase)
            2'h0:    real_i = st_i[5];
            2'h1:    real_i = -st_q[5];
            2'h2:    real_i = -st_i[5];
            default: real_i = st_q[5];
        endcase
    end

    // Output stage with gain and complex-to-real selection
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            two_valid_out <= 1'b0;
            two_i_out     <= '0;
            two_q_out     <= '0;
            c2r_phase     <= 2'h0;
        end else if (ce) begin
            // Never flag stale data as new while the chain is cleared
            two_valid_out <= st_valid[5] && !cfg_clear;
            if (cfg_clear) begin
                c2r_phase <= 2'h0;
            end else if (st_valid[5]) begin
                if (c2r) begin
                    c2r_phase <= c2r_phase + 2'h1;
                    two_i_out <= gain_double ? dbl(real_i) : real_i;
                    two_q_out <= '0;
                end else begin
                    two_i_out <= gain_double ? dbl(st_i[5]) : st_i[5];
                    two_q_out <= gain_double ? dbl(st_q[5]) : st_q[5];
                end
            end
        end
    end
endmodule

// >>> sim/dmt_src.sv
// Sample source standing in for the second downconverter's input stream.
// Assumes go and slow are driven by the bench just after the clock edge.
`timescale 1ns/1ps
module dmt_src #(
    parameter int DW = 16
) (
    input  wire logic                 core_clk,
    input  wire logic                 arst_n,
    input  wire logic                 go,
    input  wire logic                 slow,
    input  wire logic signed [DW-1:0] val_a,
    input  wire logic signed [DW-1:0] val_b,
    output logic                      valid,
    output logic signed [DW-1:0]      a,
    output logic signed [DW-1:0]      b
);
    logic phase;

    // Pacing phase, used to send every other cycle when slow
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            phase <= 1'b0;
        end else begin
            phase <= ~phase;
        end
    end

    // Idle cycles carry inverted data so stale samples never pass as new
    always_comb begin
        valid = go && (!slow || phase);
        a     = valid ? val_a : ~val_a;
        b     = valid ? val_b : ~val_b;
    end
endmodule

// >>> sim/dmt_ctrl_checker.sv
// Concurrent checks on the ports of the mode and test control block.
// Assumes ce stays high while the streams run; bound to dmt_ctrl below.
`timescale 1ns/1ps
module dmt_ctrl_checker
    import dmt_pkg::*;
#(
    parameter int DW = 16
) (
    input wire logic                    core_clk,
    input wire logic                    arst_n,
    input wire logic                    ce,
    input wire logic                    reg_wr,
    input wire logic                    reg_rd,
    input wire logic [15:0]             reg_addr,
    input wire logic [7:0]              reg_wdata,
    input wire logic [7:0]              reg_rdata,
    input wire logic                    one_valid_in,
    input wire logic signed [DW-1:0]    one_i_in,
    input wire logic signed [DW-1:0]    one_q_in,
    input wire logic signed [DW-1:0]    pattern_a,
    input wire logic signed [DW-1:0]    pattern_b,
    input wire logic                    one_valid_out,
    input wire logic signed [DW-1:0]    one_i_out,
    input wire logic signed [DW-1:0]    one_q_out,
    input wire logic [PAT_SEL_BITS-1:0] pattern_select,
    input wire logic                    two_valid_in,
    input wire logic                    two_valid_out,
    input wire logic signed [DW-1:0]    two_q_out
);
    logic [7:0] test_sh;
    logic [7:0] ctrl_sh;

    // Shadow copies of the two control registers
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            test_sh <= 8'h00;
            ctrl_sh <= 8'h00;
        end else if (ce && reg_wr) begin
            if (reg_addr == ADDR_ONE_TEST) test_sh <= reg_wdata;
            if (reg_addr == ADDR_TWO_CTRL) ctrl_sh <= reg_wdata;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    a_one_valid_lat: assert property (ce && one_valid_in |=> one_valid_out)
        else $error("first stream valid late");
    a_i_select: assert property (ce && one_valid_in |=> one_i_out ==
        ($past(test_sh[BIT_TEST_I]) ? $past(pattern_a) : $past(one_i_in)))
        else $error("first stream I source wrong");
    a_q_select: assert property (ce && one_valid_in |=> one_q_out ==
        ($past(test_sh[BIT_TEST_Q]) ? $past(pattern_b) : $past(one_q_in)))
        else $error("first stream Q source wrong");
    a_one_data_hold: assert property (ce && !one_valid_in |=>
        $stable(one_i_out) && $stable(one_q_out) && !one_valid_out)
        else $error("first stream changed without valid");
    a_test_readback: assert property (ce && reg_rd && !reg_wr &&
        reg_addr == ADDR_ONE_TEST |=> reg_rdata == (test_sh & MASK_ONE_TEST))
        else $error("test register readback wrong");
    a_ctrl_readback: assert property (ce && reg_rd && !reg_wr &&
        reg_addr == ADDR_TWO_CTRL |=> reg_rdata == ctrl_sh)
        else $error("control register readback wrong");
    a_pat_select: assert property (ce && reg_wr &&
        reg_addr == ADDR_PAT_SELECT |=> pattern_select == $past(reg_wdata[3:0]))
        else $error("pattern select not updated");
    a_two_latency: assert property (two_valid_out |-> $past(two_valid_in, 7))
        else $error("second stream output without input");
    a_two_q_zero: assert property (two_valid_out && (ctrl_sh[BIT_C2R] ||
        (!ctrl_sh[BIT_MIXER] && !ctrl_sh[POS_IF_HI])) |-> two_q_out == '0)
        else $error("second stream Q not zero");

    c_test_on: cover property (ce && one_valid_in && test_sh[BIT_TEST_I]);
    c_real_out: cover property (two_valid_out && ctrl_sh[BIT_C2R]);
    c_ctrl_read: cover property (reg_rd && reg_addr == ADDR_TWO_CTRL);
endmodule

bind dmt_ctrl dmt_ctrl_checker #(.DW(DW)) dmt_ctrl_checker_i (
    .core_clk(core_clk), .arst_n(arst_n), .ce(ce), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .one_valid_in(one_valid_in),
    .one_i_in(one_i_in), .one_q_in(one_q_in), .pattern_a(pattern_a),
    .pattern_b(pattern_b), .one_valid_out(one_valid_out),
    .one_i_out(one_i_out), .one_q_out(one_q_out),
    .pattern_select(pattern_select), .two_valid_in(two_valid_in),
    .two_valid_out(two_valid_out), .two_q_out(two_q_out));

// >>> sim/dmt_ctrl_tb.sv
// Self-checking bench for the downconverter mode and test control block.
// Assumes the checker is bound in and the sample source model is compiled.
`timescale 1ns/1ps
module dmt_ctrl_tb
    import dmt_pkg::*;
;
    localparam int DW = 16;
    localparam int DEC_BASE [7] = '{4, 8, 16, 2, 6, 12, 24};
    // Rows: control, A, B, expected I, expected Q
    localparam logic [71:0] ROWS [6] = '{
        {8'hD3, 16'h0100, 16'h0040, 16'h0200, 16'h0080},
        {8'h93, 16'h0100, 16'h0040, 16'h0100, 16'h0040},
        {8'h13, 16'h0100, 16'h0040, 16'h0100, 16'h0000},
        {8'h83, 16'h0100, 16'h0040, 16'h0100, 16'h0040},
        {8'hD3, 16'h7000, 16'h9000, 16'h7FFF, 16'h8000},
        {8'hA3, 16'h0100, 16'h0040, 16'hFF60, 16'h0060}};

    logic                 core_clk = 1'b0;
    logic                 ce = 1'b1;
    logic                 arst_n = 1'b0;
    logic                 reg_wr = 1'b0;
    logic                 reg_rd = 1'b0;
    logic [15:0]          reg_addr = 16'h0000;
    logic [7:0]           reg_wdata = 8'h00;
    logic [7:0]           reg_rdata;
    logic                 one_valid_in = 1'b0;
    logic signed [DW-1:0] one_i_in = '0;
    logic signed [DW-1:0] one_q_in = '0;
    logic signed [DW-1:0] pattern_a = '0;
    logic signed [DW-1:0] pattern_b = '0;
    logic                 one_valid_out;
    logic signed [DW-1:0] one_i_out;
    logic signed [DW-1:0] one_q_out;
    logic [3:0]           pattern_select;
    logic                 two_go = 1'b0;
    logic                 two_slow = 1'b0;
    logic signed [DW-1:0] two_a_val = 16'h0100;
    logic signed [DW-1:0] two_b_val = 16'h0040;
    logic                 two_valid_in;
    logic signed [DW-1:0] two_a_in;
    logic signed [DW-1:0] two_b_in;
    logic                 two_valid_out;
    logic signed [DW-1:0] two_i_out;
    logic signed [DW-1:0] two_q_out;
    int                   err_total = 0;
    int                   check_count = 0;
    int                   n_in = 0;
    int                   n_out = 0;

    dmt_ctrl #(.DW(DW)) dmt_ctrl_i (
        .core_clk(core_clk), .arst_n(arst_n), .ce(ce), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .one_valid_in(one_valid_in),
        .one_i_in(one_i_in), .one_q_in(one_q_in), .pattern_a(pattern_a),
        .pattern_b(pattern_b), .one_valid_out(one_valid_out),
        .one_i_out(one_i_out), .one_q_out(one_q_out),
        .pattern_select(pattern_select), .two_valid_in(two_valid_in),
        .two_a_in(two_a_in), .two_b_in(two_b_in),
        .two_valid_out(two_valid_out), .two_i_out(two_i_out),
        .two_q_out(two_q_out));

    dmt_src #(.DW(DW)) dmt_src_i (
        .core_clk(core_clk), .arst_n(arst_n), .go(two_go), .slow(two_slow),
        .val_a(two_a_val), .val_b(two_b_val), .valid(two_valid_in),
        .a(two_a_in), .b(two_b_in));

    // 200 MHz clock
    always #2.5 core_clk = ~core_clk;

    // Sample counters for the second stream
    always @(posedge core_clk) begin
        if (two_valid_in) n_in++;
        if (two_valid_out) n_out++;
    end

    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [15:0] ad, input logic [7:0] d);
        @(posedge core_clk);
        #1 reg_wr = 1'b1;
        reg_addr = ad;
        reg_wdata = d;
        @(posedge core_clk);
        #1 reg_wr = 1'b0;
    endtask

    task automatic rd(input logic [15:0] ad, output logic [7:0] d);
        @(posedge core_clk);
        #1 reg_rd = 1'b1;
        reg_addr = ad;
        @(posedge core_clk);
        #1 reg_rd = 1'b0;
        d = reg_rdata;
    endtask

    task automatic reg_test();
        logic [7:0] d;
        rd(ADDR_ONE_TEST, d);
        check("test reg reset", d, RST_ONE_TEST);
        rd(ADDR_TWO_CTRL, d);
        check("ctrl reg reset", d, RST_TWO_CTRL);
        wr(ADDR_ONE_TEST, 8'hFF);
        rd(ADDR_ONE_TEST, d);
        check("test reg mask", d, 8'h05);
        wr(ADDR_TWO_CTRL, 8'hA5);
        rd(ADDR_TWO_CTRL, d);
        check("ctrl reg", d, 8'hA5);
        wr(ADDR_PAT_SELECT, 8'hFF);
        rd(ADDR_PAT_SELECT, d);
        check("select reg", d, 8'h0F);
        check("select port", 16'(pattern_select), 16'h000F);
        // A write while the clock enable is low must not land
        ce = 1'b0;
        wr(ADDR_TWO_CTRL, 8'h11);
        ce = 1'b1;
        rd(ADDR_TWO_CTRL, d);
        check("ce frozen", d, 8'hA5);
        rd(16'h0348, d);
        check("unmapped", d, 8'h00);
    endtask

    // Every combination of the two substitution bits
    task automatic one_test();
        logic [7:0] m;
        for (int k = 0; k < 4; k++) begin
            m = {5'h00, k[1], 1'b0, k[0]};
            wr(ADDR_ONE_TEST, m);
            @(posedge core_clk);
            #1 one_valid_in = 1'b1;
            one_i_in = 16'h1230 + 16'(k);
            one_q_in = 16'h4560 + 16'(k);
            pattern_a = 16'h0A00 + 16'(k);
            pattern_b = 16'h0B00 + 16'(k);
            @(posedge core_clk);
            #1 one_valid_in = 1'b0;
            one_i_in = ~one_i_in;
            check("one valid", 16'(one_valid_out), 16'h0001);
            check("one i", one_i_out, m[0] ? 16'h0A00 + 16'(k) : 16'h1230 + 16'(k));
            check("one q", one_q_out, m[2] ? 16'h0B00 + 16'(k) : 16'h4560 + 16'(k));
        end
    endtask

    task automatic run(input int n, input logic s);
        @(posedge core_clk);
        #1 two_slow = s;
        two_go = 1'b1;
        repeat (n) @(posedge core_clk);
        #1 two_go = 1'b0;
        repeat (12) @(posedge core_clk);
    endtask

    // Mixer type, gain, saturation and all IF modes but test, on half-band one
    task automatic two_data();
        for (int r = 0; r < 6; r++) begin
            two_a_val = ROWS[r][63:48];
            two_b_val = ROWS[r][47:32];
            wr(ADDR_TWO_CTRL, ROWS[r][71:64]);
            run(20, 1'b0);
            check("two i", two_i_out, ROWS[r][31:16]);
            check("two q", two_q_out, ROWS[r][15:0]);
        end
    endtask

    // Output count per decimation code, both with and without real output
    task automatic two_rate();
        int dec;
        two_a_val = 16'h0100;
        for (int c = 0; c < 14; c++) begin
            dec = DEC_BASE[c % 7] >> (c / 7);
            wr(ADDR_TWO_CTRL, {4'h9, 1'(c / 7), 3'(c % 7)});
            #1 n_in = 0;
            n_out = 0;
            run(480, 1'(c / 7));
            check("two rate", 16'(n_out), 16'(n_in / dec));
            if (c >= 7) check("two real q", two_q_out, 16'h0000);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Watchdog
    initial begin
        repeat (40000) @(posedge core_clk);
        err_total++;
        conclude();
    end

    // Main sequence
    initial begin
        repeat (2) @(posedge core_clk);
        #1 arst_n = 1'b1;
        reg_test();
        one_test();
        two_data();
        two_rate();
        conclude();
    end
endmodule
